// ---- design/zdo_pkg.sv ----
// Package: register map, field layout, reset values and counts for the zero-detect block
package zdo_pkg;
  // Control word layout on the 3-wire port
  localparam int          WORD_W          = 16;
  localparam int          IDX_HI          = 14;
  localparam int          IDX_LO          = 8;
  localparam logic [6:0]  IDX_FILTER_FMT  = 7'h14;
  localparam logic [6:0]  IDX_ZERO_PHASE  = 7'h16;
  // Field positions
  localparam int          ROLLOFF_BIT     = 5;
  localparam int          PHASE_BIT       = 0;
  localparam int          POLARITY_BIT    = 1;
  localparam int          COMMON_BIT      = 2;
  // Reset values
  localparam logic [7:0]  FILTER_FMT_RST  = 8'h05;
  localparam logic [7:0]  ZERO_PHASE_RST  = 8'h00;
  // Zero-detect length in word-clock periods
  localparam int          ZERO_PERIODS    = 1024;
  localparam int          CNT_W           = 11;
  localparam int          SAMPLE_W        = 24;

  // Decoded mode bits
  typedef struct packed {
    logic rolloff_select;
    logic output_phase_invert;
    logic flag_polarity_invert;
    logic common_flag_mode;
  } zdo_mode_t;

  // One received stereo sample
  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } zdo_sample_t;
endpackage : zdo_pkg

// ---- design/zdo_zero_counter.sv ----
// Module: per-channel run-length counter of zero samples
module zdo_zero_counter
(
  input  wire logic                         sys_clk_i,
  input  wire logic                         nrst_i,
  input  wire logic                         sample_stb_i,
  input  wire logic [zdo_pkg::SAMPLE_W-1:0] sample_i,
  output logic                              zero_o
);
  logic [zdo_pkg::CNT_W-1:0] cnt_q;
  logic [zdo_pkg::CNT_W-1:0] cnt_d;
  wire                       sample_zero;
  wire                       cnt_full;

  assign sample_zero = (sample_i == '0);
  // Saturates so a long silence never wraps back to inactive
  assign cnt_full    = (cnt_q == zdo_pkg::CNT_W'(zdo_pkg::ZERO_PERIODS));

  // Nonzero sample restarts the run at once
  always_comb
  begin
    cnt_d = cnt_q;
    if (sample_stb_i && !sample_zero)
      cnt_d = '0;
    else if (sample_stb_i && !cnt_full)
      cnt_d = cnt_q + 1'b1;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  // Condition holds after 1024 consecutive zero periods
  assign zero_o = cnt_full;
endmodule : zdo_zero_counter

// ---- design/zdo_zero_flags.sv ----
// Module: control word capture, mode bits and zero-flag pin generation
// Timing, counted in sys_clk_i edges
// Control word taken on the edge where its strobe is high
// Mode outputs follow straight from the register images
// Flag pins move one edge after the images; raw flags ignore them
// Zero runs are counted in sample strobes, never in clocks
// Flags rise one edge after the 1024th zero strobe
// Flags fall one edge after the first nonzero strobe
//
// Sample path
// One strobe per word_select_clock period carries both channels
// Left channel sits in the upper half of the sample word
// One nonzero channel restarts only its own run
//
// Pin behaviour
// Split mode: first pin is right channel, second pin left
// Common mode: first pin needs both channels silent
// Common mode: second pin released, its output enable low
// Polarity bit flips driven pins only, never the raw flags
//
// Reset
// Asynchronous and active low; images load their defaults, runs clear
// Flags come up inactive, second pin enabled and low
//
// Limitations
// Serial deframing of the 3-wire port lives outside
// Reserved bits kept as written and never acted on
// Format field kept for the filter path, unused here
// Released pin level is set by the board, not here
// Run length fixed; a different run needs a new count
module zdo_zero_flags
(
  input  wire logic                    sys_clk_i,
  input  wire logic                    nrst_i,
  // Control port, one completed 16-bit word per strobe
  input  wire logic                    ctrl_word_stb_i,
  input  wire logic [15:0]             ctrl_word_i,
  // Sample stream, one strobe per word_select_clock period
  input  wire logic                    word_select_clock_stb_i,
  input  wire zdo_pkg::zdo_sample_t    sample_i,
  // Mode outputs toward filter and output stage
  output logic                         rolloff_select_o,
  output logic                         output_phase_invert_o,
  // Zero-flag pins
  output logic                         flag_pin_a_o,
  output logic                         flag_pin_b_o,
  output logic                         flag_pin_b_oe_o,
  // Raw per-channel conditions for status logic
  output logic                         left_channel_flag_o,
  output logic                         right_channel_flag_o,
  output logic                         combined_channel_flag_o
);
  // Channel 0 is right, channel 1 is left, matching pin order
  localparam int     NUM_CHAN = 2;

  // Register images, written only by accepted control words
  logic [7:0]        zero_phase_q;
  logic [7:0]        zero_phase_d;
  logic [7:0]        filter_fmt_q;
  logic [7:0]        filter_fmt_d;

  // Pin stage; all three pins move on one edge
  logic              pin_a_q;
  logic              pin_a_d;
  logic              pin_b_q;
  logic              pin_b_d;
  logic              pin_b_oe_q;
  logic              pin_b_oe_d;

  // Raw conditions, delayed to line up with the pins
  logic              left_q;
  logic              right_q;
  logic              comb_q;

  // Per-channel conditions from the run counters
  wire               left_zero;
  wire               right_zero;
  wire               both_zero;
  wire  [NUM_CHAN-1:0] chan_zero;
  wire  [zdo_pkg::SAMPLE_W-1:0] chan_sample [NUM_CHAN];

  // Write decode
  wire               word_valid;
  wire  [6:0]        word_index;
  wire               hit_zero_phase;
  wire               hit_filter_fmt;

  // Decoded mode bits
  zdo_pkg::zdo_mode_t mode;

  // Index match; used for both writable registers
  // Kept as a function so another register costs one line
  function automatic logic idx_hit(input logic [6:0] got_idx, input logic [6:0] want_idx);
    idx_hit = (got_idx == want_idx);
  endfunction : idx_hit

  // A word with MSB set is malformed and dropped whole
  // Foreign indices fall through; other blocks own them
  assign word_valid     = ctrl_word_stb_i && !ctrl_word_i[zdo_pkg::WORD_W-1];
  assign word_index     = ctrl_word_i[zdo_pkg::IDX_HI:zdo_pkg::IDX_LO];
  assign hit_zero_phase = word_valid && idx_hit(word_index, zdo_pkg::IDX_ZERO_PHASE);
  assign hit_filter_fmt = word_valid && idx_hit(word_index, zdo_pkg::IDX_FILTER_FMT);

  // Reserved bits are stored as written; host keeps them zero
  // Images hold their value between writes; only reset reloads them
  assign zero_phase_d = hit_zero_phase ? ctrl_word_i[7:0] : zero_phase_q;
  assign filter_fmt_d = hit_filter_fmt ? ctrl_word_i[7:0] : filter_fmt_q;

  // Both images reset to their documented defaults
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      zero_phase_q <= zdo_pkg::ZERO_PHASE_RST;
      filter_fmt_q <= zdo_pkg::FILTER_FMT_RST;
    end
    else
    begin
      zero_phase_q <= zero_phase_d;
      filter_fmt_q <= filter_fmt_d;
    end
  end

  // Mode field decode; one assignment keeps a single driver
  assign mode = '{
    rolloff_select:       filter_fmt_q[zdo_pkg::ROLLOFF_BIT],
    output_phase_invert:  zero_phase_q[zdo_pkg::PHASE_BIT],
    flag_polarity_invert: zero_phase_q[zdo_pkg::POLARITY_BIT],
    common_flag_mode:     zero_phase_q[zdo_pkg::COMMON_BIT]
  };
  // Mode outputs are register bits, so they never glitch
  assign rolloff_select_o          = mode.rolloff_select;
  assign output_phase_invert_o     = mode.output_phase_invert;

  // Right is channel 0 to match the first pin in split mode
  assign chan_sample[0] = sample_i.right;
  assign chan_sample[1] = sample_i.left;

  // One counter per channel, independent of each other
  // Both see the same strobe; only the data differs
  for (genvar ch = 0; ch < NUM_CHAN; ch++)
  begin : g_chan
    zdo_zero_counter u_count
    (
      .sys_clk_i    (sys_clk_i),
      .nrst_i       (nrst_i),
      .sample_stb_i (word_select_clock_stb_i),
      .sample_i     (chan_sample[ch]),
      .zero_o       (chan_zero[ch])
    );
  end

  // Names kept for the flag selection below
  assign right_zero = chan_zero[0];
  assign left_zero  = chan_zero[1];

  // Combined flag is an AND so one live channel keeps mute off
  assign both_zero = left_zero && right_zero;

  // Pin selection and polarity; pins are registered to stay glitch free
  // Released pin is driven low too, so nothing undefined reaches the pad
  always_comb
  begin
    // Split mode: right on the first pin, left on the second
    pin_a_d    = right_zero;
    pin_b_d    = left_zero;
    pin_b_oe_d = 1'b1;
    if (mode.common_flag_mode)
    begin
      pin_a_d    = both_zero;
      pin_b_d    = 1'b0;
      pin_b_oe_d = 1'b0; // Unassigned pin floats
    end
    // Active-high by default, inverted when polarity bit set
    pin_a_d = pin_a_d ^ mode.flag_polarity_invert;
    pin_b_d = pin_b_oe_d & (pin_b_d ^ mode.flag_polarity_invert);
  end

  // Pins and raw flags share one stage so they move together
  // Second pin enable resets high: split mode is the default
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      // Inactive flags at default polarity
      pin_a_q    <= 1'b0;
      pin_b_q    <= 1'b0;
      pin_b_oe_q <= 1'b1;
      left_q     <= 1'b0;
      right_q    <= 1'b0;
      comb_q     <= 1'b0;
    end
    else
    begin
      // Flags follow the counters one edge late
      pin_a_q    <= pin_a_d;
      pin_b_q    <= pin_b_d;
      pin_b_oe_q <= pin_b_oe_d;
      left_q     <= left_zero;
      right_q    <= right_zero;
      comb_q     <= both_zero;
    end
  end

  // Outputs straight from flip-flops; no logic after them
  assign flag_pin_a_o            = pin_a_q;
  assign flag_pin_b_o            = pin_b_q;
  assign flag_pin_b_oe_o         = pin_b_oe_q;
  assign left_channel_flag_o     = left_q;
  assign right_channel_flag_o    = right_q;
  assign combined_channel_flag_o = comb_q;
endmodule : zdo_zero_flags

// ---- bench/zdo_zero_flags_properties.sv ----
// Checker: port-level properties of the zero-flag block
module zdo_checker
(
  input wire logic                 sys_clk_i,
  input wire logic                 nrst_i,
  input wire logic                 ctrl_word_stb_i,
  input wire logic [15:0]          ctrl_word_i,
  input wire logic                 word_select_clock_stb_i,
  input wire zdo_pkg::zdo_sample_t sample_i,
  input wire logic                 rolloff_select_o,
  input wire logic                 output_phase_invert_o,
  input wire logic                 flag_pin_a_o,
  input wire logic                 flag_pin_b_o,
  input wire logic                 flag_pin_b_oe_o,
  input wire logic                 left_channel_flag_o,
  input wire logic                 right_channel_flag_o,
  input wire logic                 combined_channel_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Accepted writes; MSB set or foreign index is dropped
  wire ok   = ctrl_word_stb_i && !ctrl_word_i[15];
  wire wr16 = ok && (ctrl_word_i[14:8] == zdo_pkg::IDX_ZERO_PHASE);
  wire wr14 = ok && (ctrl_word_i[14:8] == zdo_pkg::IDX_FILTER_FMT);
  logic [10:0] cl_q;
  logic [10:0] cr_q;
  logic [2:0]  md_q;
  // Shadow zero runs saturate so a long silence never wraps
  always_ff @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
      {cl_q, cr_q, md_q} <= '0;
    else
    begin
      if (word_select_clock_stb_i)
        cl_q <= (sample_i.left != '0) ? 11'h000 : cl_q + 11'(cl_q != 11'h400);
      if (word_select_clock_stb_i)
        cr_q <= (sample_i.right != '0) ? 11'h000 : cr_q + 11'(cr_q != 11'h400);
      if (wr16)
        md_q <= ctrl_word_i[2:0];
    end
  property p_left; left_channel_flag_o == $past(cl_q == 11'h400); endproperty
  a_left: assert property (p_left) else $error("left flag wrong");
  property p_right; right_channel_flag_o == $past(cr_q == 11'h400); endproperty
  a_right: assert property (p_right) else $error("right flag wrong");
  property p_comb; combined_channel_flag_o == (left_channel_flag_o && right_channel_flag_o);
  endproperty
  a_comb: assert property (p_comb) else $error("combined flag wrong");
  property p_pina; flag_pin_a_o == ($past(md_q[1]) ^
    ($past(md_q[2]) ? combined_channel_flag_o : right_channel_flag_o)); endproperty
  a_pina: assert property (p_pina) else $error("first pin wrong");
  property p_pinb; flag_pin_b_o == (!$past(md_q[2]) && ($past(md_q[1]) ^ left_channel_flag_o));
  endproperty
  a_pinb: assert property (p_pinb) else $error("second pin wrong");
  property p_oe; flag_pin_b_oe_o == !$past(md_q[2]); endproperty
  a_oe: assert property (p_oe) else $error("second pin enable wrong");
  property p_phase; output_phase_invert_o == md_q[0]; endproperty
  a_phase: assert property (p_phase) else $error("phase bit wrong");
  property p_roll; wr14 |=> rolloff_select_o == $past(ctrl_word_i[5]); endproperty
  a_roll: assert property (p_roll) else $error("rolloff not taken");
  property p_hold; !wr14 |=> $stable(rolloff_select_o); endproperty
  a_hold: assert property (p_hold) else $error("rolloff moved");
  // Main scenarios
  c_comb: cover property (md_q[2] && flag_pin_a_o);
  c_inv: cover property (md_q[1] && !flag_pin_a_o);
  c_drop: cover property (left_channel_flag_o && !right_channel_flag_o);
endmodule : zdo_checker
bind zdo_zero_flags zdo_checker u_chk (.*);

// ---- bench/zdo_host_model.sv ----
// Partner: host writing whole control words into the block
module zdo_host_model
(
  input  wire logic   sys_clk_i,
  output logic        ctrl_word_stb_o,
  output logic [15:0] ctrl_word_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {ctrl_word_stb_o, ctrl_word_o} = '0;
  // Reserved bits forced to zero; released word shows inverted value
  task automatic send(input logic top, input logic [6:0] idx, input logic [7:0] dat);
    @(posedge sys_clk_i);
    #1 ctrl_word_stb_o = 1'b1;
    ctrl_word_o = {top, idx, dat & ((idx == 7'h16) ? 8'h07 : 8'h27)};
    @(posedge sys_clk_i);
    #1 ctrl_word_stb_o = 1'b0;
    ctrl_word_o = ~ctrl_word_o;
  endtask : send
endmodule : zdo_host_model

// ---- bench/tb_zdo_zero_flags.sv ----
// Testbench: mode writes, zero runs and flag pins of the zero-flag block
module tb_zdo_zero_flags;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i, nrst_i, ws, cs, ro, ph, pa, pb, oe, lf, rf, cf;
  logic [15:0] cw;
  zdo_pkg::zdo_sample_t smp;
  int num_errors = 0;
  int comparisons = 0;
  zdo_host_model u_host (.sys_clk_i(sys_clk_i), .ctrl_word_stb_o(cs), .ctrl_word_o(cw));
  zdo_zero_flags u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ctrl_word_stb_i(cs),
    .ctrl_word_i(cw), .word_select_clock_stb_i(ws), .sample_i(smp), .rolloff_select_o(ro),
    .output_phase_invert_o(ph), .flag_pin_a_o(pa), .flag_pin_b_o(pb), .flag_pin_b_oe_o(oe),
    .left_channel_flag_o(lf), .right_channel_flag_o(rf), .combined_channel_flag_o(cf));
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
    end
  endtask : chk
  // Back-to-back sample strobes, then one edge for flags to land
  task automatic feed(input int n, input logic [23:0] l, input logic [23:0] r);
    repeat (n)
    begin
      @(posedge sys_clk_i);
      #1 ws = 1'b1;
      smp = {l, r};
    end
    @(posedge sys_clk_i);
    #1 ws = 1'b0;
    smp = ~smp;
    @(posedge sys_clk_i);
    #1;
  endtask : feed
  // Pins follow a write one edge after the mode bits
  task automatic wr(input logic top, input logic [6:0] idx, input logic [7:0] dat);
    u_host.send(top, idx, dat);
    @(posedge sys_clk_i);
    #1;
  endtask : wr
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // Run is about 2100 cycles; cut off well beyond
  initial
  begin
    #1000000;
    num_errors++;
    $display("CHECK FAILED at %0t: run hung", $time);
    complete_run();
  end
  initial
  begin
    {nrst_i, ws, smp} = '0;
    repeat (3) @(posedge sys_clk_i);
    #1 nrst_i = 1'b1;
    chk(ro, 1'b0);
    chk(ph, 1'b0);
    chk(oe, 1'b1);
    chk(pa | pb, 1'b0);
    $display("test reset done");
    feed(1023, 24'h000000, 24'h000001);
    chk(lf, 1'b0);
    feed(1, 24'h000000, 24'h000001);
    chk(lf, 1'b1);
    chk(pb, 1'b1);
    chk(pa, 1'b0);
    $display("test left run done");
    feed(1024, 24'h000000, 24'h000000);
    chk(rf, 1'b1);
    chk(cf, 1'b1);
    chk(pa, 1'b1);
    wr(1'b0, 7'h16, 8'h02);
    chk(pa | pb, 1'b0);
    wr(1'b0, 7'h16, 8'h04);
    chk(pa, 1'b1);
    chk(oe | pb, 1'b0);
    feed(1, 24'h000000, 24'h000005);
    chk(rf | cf | pa, 1'b0);
    chk(lf, 1'b1);
    $display("test flag modes done");
    wr(1'b0, 7'h14, 8'h20);
    chk(ro, 1'b1);
    wr(1'b0, 7'h16, 8'h01);
    chk(ph & oe, 1'b1);
    wr(1'b1, 7'h16, 8'h00);
    wr(1'b0, 7'h17, 8'h00);
    chk(ph, 1'b1);
    wr(1'b0, 7'h14, 8'h00);
    chk(ro, 1'b0);
    $display("test writes done");
    nrst_i = 1'b0;
    @(posedge sys_clk_i);
    #1 nrst_i = 1'b1;
    chk(ph | lf, 1'b0);
    chk(oe, 1'b1);
    $display("test second reset done");
    complete_run();
  end
endmodule : tb_zdo_zero_flags
